// ==== rtl/mpfr_params.svh ====
`ifndef MPFR_PARAMS_SVH
`define MPFR_PARAMS_SVH
// ==========================================================
// clock and timing
`define MPFR_CLK_HZ          25000000
`define MPFR_RUN_WAIT_MS     2000
`define MPFR_DELAY_STEP_MS   100
`define MPFR_RUN_WAIT_CYC    (`MPFR_CLK_HZ / 1000 * `MPFR_RUN_WAIT_MS)
`define MPFR_DELAY_STEP_CYC  (`MPFR_CLK_HZ / 1000 * `MPFR_DELAY_STEP_MS)
// ==========================================================
// register indices
`define MPFR_NREG            14
`define MPFR_IDX_CAP         0
`define MPFR_IDX_CUR         1
`define MPFR_IDX_TUNE        2
`define MPFR_IDX_NOLOAD      3
`define MPFR_IDX_R1          4
`define MPFR_IDX_X           5
`define MPFR_IDX_GDRV        6
`define MPFR_IDX_RESP        7
`define MPFR_IDX_GBRK        8
`define MPFR_IDX_SLIP        9
`define MPFR_IDX_MODE        10
`define MPFR_IDX_START       11
`define MPFR_IDX_DELAY       12
`define MPFR_IDX_THRESH      13
// ==========================================================
// offsets
`define MPFR_OFFSETS '{16'h0201, 16'h0202, 16'h0203, 16'h0204, \
   16'h0205, 16'h0206, 16'h0207, 16'h0208, 16'h0209, 16'h020A, \
   16'h000C, 16'h0012, 16'h0319, 16'h031B}
`define MPFR_OFF_STATUS      16'h0340
// ==========================================================
// reset values, legal minimum and maximum
`define MPFR_RESETS  '{16'd40, 16'd210, 16'd0, 16'd152, 16'd847, \
   16'd1134, 16'd1000, 16'd100, 16'd1000, 16'd240, 16'd1, 16'd10, \
   16'd5, 16'd235}
`define MPFR_MINS    '{16'd1, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0, \
   16'd0, 16'd1, 16'd0, 16'd0, 16'd0, 16'd1, 16'd1, 16'd200}
`define MPFR_MAXS    '{16'd3000, 16'd10000, 16'd1, 16'd5000, \
   16'd5000, 16'd5000, 16'd2000, 16'd1000, 16'd2000, 16'd1500, \
   16'd5, 16'd600, 16'd100, 16'd300}
`endif

// ==== rtl/mpfr_pkg.sv ====
`default_nettype none
package mpfr_pkg;
   // ==========================================================
   // restart modes
   typedef enum logic [15:0] {
      MODE_TRIP_NOW   = 16'h0000,
      MODE_TRIP_AFTER = 16'h0001,
      MODE_DECEL_STOP = 16'h0002,
      MODE_RESERVED   = 16'h0003,
      MODE_RESUME     = 16'h0004,
      MODE_FROM_START = 16'h0005
   } mpfr_mode_t;
   // ==========================================================
   // sequencer states
   typedef enum logic [4:0] {
      ST_IDLE     = 5'b0_0001,
      ST_DECEL    = 5'b0_0010,
      ST_FAIL     = 5'b0_0100,
      ST_WAIT_RUN = 5'b0_1000,
      ST_TRIP     = 5'b1_0000
   } mpfr_state_t;
endpackage
`default_nettype wire

// ==== rtl/mpfr_timer.sv ====
`default_nettype none
module mpfr_timer
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // control
   input  wire logic        start,
   input  wire logic [31:0] load,
   // status
   output logic             expired
);
   logic [31:0] count;
   logic        active;

   // ==========================================================
   // down counter, expiry held until next start
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count   <= 32'h0000_0000;
         active  <= 1'b0;
         expired <= 1'b0;
      end else if (start) begin
         count   <= load;
         active  <= 1'b1;
         expired <= 1'b0;
      end else if (active) begin
         if (count <= 32'h0000_0001) begin
            active  <= 1'b0;
            expired <= 1'b1;
         end else begin
            count <= count - 32'h0000_0001;
         end
      end
   end
endmodule // mpfr_timer
`default_nettype wire

// ==== rtl/mpfr_regfile.sv ====
`include "mpfr_params.svh"
`default_nettype none
module mpfr_regfile
   import mpfr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // register port
   input  wire logic [15:0] regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output logic      [15:0] regRdData,
   output logic             regAck,
   output logic             regErr,
   // block state and tuning results
   input  wire logic [15:0] statusWord,
   input  wire logic        tuneDone,
   input  wire logic [15:0] tuneNoLoad,
   input  wire logic [15:0] tuneR1,
   input  wire logic [15:0] tuneX,
   input  wire logic [15:0] tuneSlip,
   // stored values
   output logic      [15:0] regVal [`MPFR_NREG],
   output logic             tuneReq
);
   localparam int NREG = `MPFR_NREG;
   localparam logic [15:0] OFFS [NREG] = `MPFR_OFFSETS;
   localparam logic [15:0] RSTV [NREG] = `MPFR_RESETS;
   localparam logic [15:0] MINV [NREG] = `MPFR_MINS;
   localparam logic [15:0] MAXV [NREG] = `MPFR_MAXS;

   logic [NREG-1:0] hit;
   logic [NREG-1:0] legal;
   logic [NREG-1:0] tuned;
   logic [15:0]     tunedWord [NREG];
   logic [15:0]     next_rdData;
   wire             anyHit     = |hit;
   wire             legalHit   = |(hit & legal);
   wire             statusHit  = (regAddr == `MPFR_OFF_STATUS);
   wire             tuneWrite  = regWrEn && hit[`MPFR_IDX_TUNE] &&
                                 legal[`MPFR_IDX_TUNE];

   // ==========================================================
   // per register decode, range check and storage
   genvar i;
   generate
      for (i = 0; i < NREG; i++) begin : g_reg
         assign hit[i]   = (regAddr == OFFS[i]);
         assign legal[i] = (regWrData >= MINV[i]) && // see R12 R13 R14 R15
                           (regWrData <= MAXV[i]) &&
                           !(i == `MPFR_IDX_MODE &&
                             regWrData == MODE_RESERVED); // see R20
         assign tuned[i] = (i == `MPFR_IDX_NOLOAD) ||
                           (i == `MPFR_IDX_R1) || (i == `MPFR_IDX_X) ||
                           (i == `MPFR_IDX_SLIP) ||
                           (i == `MPFR_IDX_TUNE);
         assign tunedWord[i] =
            (i == `MPFR_IDX_NOLOAD) ? tuneNoLoad :
            (i == `MPFR_IDX_R1)     ? tuneR1 :
            (i == `MPFR_IDX_X)      ? tuneX :
            (i == `MPFR_IDX_SLIP)   ? tuneSlip : 16'h0000;
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               regVal[i] <= RSTV[i];
            end else if (regWrEn && hit[i] && legal[i]) begin
               regVal[i] <= regWrData; // see R19
            end else if (tuneDone && tuned[i]) begin
               regVal[i] <= tunedWord[i]; // see R10
            end
         end
      end
   endgenerate

   // ==========================================================
   // read mux and answer
   always_comb begin
      next_rdData = 16'h0000;
      for (int k = 0; k < NREG; k++) begin
         if (hit[k]) begin
            next_rdData = regVal[k];
         end
      end
      if (statusHit) begin
         next_rdData = statusWord;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regRdData <= 16'h0000;
         regAck    <= 1'b0;
         regErr    <= 1'b0;
         tuneReq   <= 1'b0;
      end else begin
         regRdData <= regRdEn ? next_rdData : 16'h0000;
         regAck    <= regWrEn || regRdEn;
         regErr    <= ((regWrEn || regRdEn) && !anyHit && !statusHit) ||
                      (regWrEn && (statusHit || (anyHit && !legalHit)));
         tuneReq   <= tuneWrite && regWrData[0]; // see R9
      end
   end

   // ==========================================================
   // checks
   a_range_reject: assert property ( // see R19
      @(posedge clk) disable iff (!nrst)
      (regWrEn && hit[`MPFR_IDX_CAP] && !legal[`MPFR_IDX_CAP] &&
       !tuneDone)
      |=> ($stable(regVal[`MPFR_IDX_CAP]) && regErr))
      else $error("out of range write changed capacity");
   a_mode_three: assert property ( // see R20
      @(posedge clk) disable iff (!nrst)
      (regWrEn && hit[`MPFR_IDX_MODE] && regWrData == MODE_RESERVED)
      |=> (regVal[`MPFR_IDX_MODE] != MODE_RESERVED))
      else $error("reserved restart mode stored");
   a_tune_results: assert property ( // see R10
      @(posedge clk) disable iff (!nrst)
      (tuneDone && !regWrEn)
      |=> (regVal[`MPFR_IDX_R1] == $past(tuneR1) &&
           regVal[`MPFR_IDX_SLIP] == $past(tuneSlip)))
      else $error("tuning results not stored");
endmodule // mpfr_regfile
`default_nettype wire

// ==== rtl/mpfr_top.sv ====
// Summary of operation
// R1: mode 0: under-voltage raises alarm at once and cuts output.
// R2: mode 1: under-voltage cuts output, no alarm, no under-voltage state.
// R3: mode 1: alarm raised when power returns, output stays off.
// R4: mode 2: bus below running level starts decelerate-to-stop.
// R5: mode 2: alarm raised only after decelerate-to-stop has finished.
// R6: mode 4: under-voltage latches output frequency, then cuts output.
// R7: mode 4: run command at restore resumes at latched frequency.
// R8: mode 5: restore then run command restarts at starting frequency.
// R9: writing auto-tuning register starts parameter detection.
// R10: tuning end overwrites no-load, resistance, reactance, slip registers.
// R11: drive and brake slip gains kept apart, 0.1 % steps, 0 to 2000.
// R12: slip response time in 0.01 s steps, 1 to 1000, default 100.
// R13: rated capacity 0.01 kW steps, 1 to 3000, loaded by user.
// R14: rated current 0.01 A steps, 0 to 10000, loaded by user.
// R15: rated slip frequency 0.01 Hz steps, 0 to 1500.
// R16: after restore wait 2 s for run command, else cancel restart.
// R17: no restart before restart delay since the failure has elapsed.
// R18: running level threshold 200 to 300 volts, default 235.
// R19: out-of-range register writes are refused, value unchanged.
// R20: restart mode 3 is illegal and refused.
`include "mpfr_params.svh"
`default_nettype none
module mpfr_top
   import mpfr_pkg::*;
#(
   parameter int RUN_WAIT_CYC   = `MPFR_RUN_WAIT_CYC,
   parameter int DELAY_STEP_CYC = `MPFR_DELAY_STEP_CYC
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // register port
   input  wire logic [15:0] regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output logic      [15:0] regRdData,
   output logic             regAck,
   output logic             regErr,
   // power stage pins
   input  wire logic        uvDetect,
   input  wire logic        readyToRun,
   input  wire logic        runCmd,
   input  wire logic        alarmClear,
   // drive logic, same clock
   input  wire logic [15:0] dcLinkVolts,
   input  wire logic [15:0] outFreq,
   // tuning engine
   input  wire logic        tuneDone,
   input  wire logic [15:0] tuneNoLoad,
   input  wire logic [15:0] tuneR1,
   input  wire logic [15:0] tuneX,
   input  wire logic [15:0] tuneSlip,
   output logic             tuneStart,
   // drive control
   output logic             driveOn,
   output logic             decelStop,
   output logic             undervoltageAlarm,
   output logic             restartStrobe,
   output logic      [15:0] restartFreq,
   output logic      [15:0] driveSlipGain,
   output logic      [15:0] brakeSlipGain
);
   // ==========================================================
   // pin synchronisers
   logic [3:0] pinMeta;
   logic [3:0] pinSync;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pinMeta <= 4'h0;
         pinSync <= 4'h0;
      end else begin
         pinMeta <= {alarmClear, runCmd, readyToRun, uvDetect};
         pinSync <= pinMeta;
      end
   end
   wire uvS    = pinSync[0];
   wire readyS = pinSync[1];
   wire runS   = pinSync[2];
   wire clrS   = pinSync[3];

   // ==========================================================
   // register file
   logic [15:0] regVal [`MPFR_NREG];
   logic [15:0] statusWord;
   logic        tuneReq;
   mpfr_state_t state;
   mpfr_state_t next_state;
   logic [15:0] savedFreq;
   logic        runSeen;

   assign statusWord = {8'h00, runSeen, undervoltageAlarm, decelStop,
                        driveOn ? state : 5'b0_0000};

   mpfr_regfile u_regs (
      .clk        (clk),
      .nrst       (nrst),
      .regAddr    (regAddr),
      .regWrData  (regWrData),
      .regWrEn    (regWrEn),
      .regRdEn    (regRdEn),
      .regRdData  (regRdData),
      .regAck     (regAck),
      .regErr     (regErr),
      .statusWord (statusWord),
      .tuneDone   (tuneDone),
      .tuneNoLoad (tuneNoLoad),
      .tuneR1     (tuneR1),
      .tuneX      (tuneX),
      .tuneSlip   (tuneSlip),
      .regVal     (regVal),
      .tuneReq    (tuneReq)
   );

   wire [15:0] modeVal   = regVal[`MPFR_IDX_MODE];
   wire [15:0] startFreq = regVal[`MPFR_IDX_START];
   wire [15:0] threshold = regVal[`MPFR_IDX_THRESH]; // see R18
   wire [15:0] delaySet  = regVal[`MPFR_IDX_DELAY];
   wire        mode0     = (modeVal == MODE_TRIP_NOW);
   wire        mode1     = (modeVal == MODE_TRIP_AFTER);
   wire        mode2     = (modeVal == MODE_DECEL_STOP);
   wire        mode4     = (modeVal == MODE_RESUME);

   // ==========================================================
   // event decode
   wire inIdle     = (state == ST_IDLE);
   wire lowBus     = inIdle && driveOn && mode2 &&
                     (dcLinkVolts < threshold); // see R4
   wire uvEvent    = inIdle && driveOn && uvS && !lowBus;
   wire tripNow    = uvEvent && (mode0 || mode2); // see R1
   wire failNow    = uvEvent && !(mode0 || mode2); // see R2
   wire decelDone  = (state == ST_DECEL) && (outFreq == 16'h0000);
   wire restoreNow = (state == ST_FAIL) && readyS;
   wire runAny     = runSeen || runS;
   logic delayExp;
   logic windowExp;
   wire restartNow = (state == ST_WAIT_RUN) && runS &&
                     delayExp; // see R17
   wire cancelNow  = (state == ST_WAIT_RUN) && windowExp &&
                     !runAny; // see R16
   wire normalRun  = inIdle && !driveOn && runS && !undervoltageAlarm;
   wire [31:0] delayLoad = 32'(delaySet) * 32'(DELAY_STEP_CYC);

   // ==========================================================
   // restart delay and run window timers
   mpfr_timer u_delay (
      .clk     (clk),
      .nrst    (nrst),
      .start   (failNow),
      .load    (delayLoad),
      .expired (delayExp)
   );

   mpfr_timer u_window (
      .clk     (clk),
      .nrst    (nrst),
      .start   (restoreNow && !mode1),
      .load    (32'(RUN_WAIT_CYC)),
      .expired (windowExp)
   );

   // ==========================================================
   // sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (lowBus) begin
               next_state = ST_DECEL;
            end else if (tripNow) begin
               next_state = ST_TRIP;
            end else if (failNow) begin
               next_state = ST_FAIL;
            end
         end
         ST_DECEL: begin
            if (decelDone) begin
               next_state = ST_TRIP; // see R5
            end
         end
         ST_FAIL: begin
            if (restoreNow) begin
               next_state = mode1 ? ST_TRIP : ST_WAIT_RUN; // see R3
            end
         end
         ST_WAIT_RUN: begin
            if (restartNow || cancelNow) begin
               next_state = ST_IDLE;
            end
         end
         ST_TRIP: begin
            if (clrS) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   wire next_driveOn = restartNow || normalRun ||
                       (driveOn && inIdle && runS &&
                        !uvEvent) ||
                       (driveOn && (lowBus ||
                        (state == ST_DECEL && !decelDone)));
   wire next_alarm   = (tripNow && mode0) || decelDone ||
                       (restoreNow && mode1) ||
                       (undervoltageAlarm && !clrS);
   wire [15:0] next_restartFreq =
      (restartNow && mode4) ? savedFreq : startFreq; // see R7, R8

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         driveOn           <= 1'b0;
         decelStop         <= 1'b0;
         undervoltageAlarm <= 1'b0;
      end else begin
         driveOn           <= next_driveOn; // see R1, R2, R6
         decelStop         <= lowBus ||
                              (decelStop && !decelDone); // see R4
         undervoltageAlarm <= next_alarm; // see R1, R3, R5
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         savedFreq     <= 16'h0000;
         runSeen       <= 1'b0;
         restartStrobe <= 1'b0;
         restartFreq   <= 16'h0000;
      end else begin
         if (failNow && mode4) begin
            savedFreq <= outFreq; // see R6
         end
         runSeen       <= (state == ST_WAIT_RUN) && runAny &&
                          !restartNow;
         restartStrobe <= restartNow || normalRun;
         if (restartNow || normalRun) begin
            restartFreq <= next_restartFreq;
         end
      end
   end

   // ==========================================================
   // tuning and slip gains
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tuneStart     <= 1'b0;
         driveSlipGain <= 16'h0000;
         brakeSlipGain <= 16'h0000;
      end else begin
         tuneStart     <= tuneReq || (tuneStart && !tuneDone); // see R9
         driveSlipGain <= regVal[`MPFR_IDX_GDRV]; // see R11
         brakeSlipGain <= regVal[`MPFR_IDX_GBRK]; // see R11
      end
   end

   // ==========================================================
   // checks
   a_mode0_trip: assert property ( // see R1
      @(posedge clk) disable iff (!nrst)
      (tripNow && mode0)
      |=> (undervoltageAlarm && !driveOn && state == ST_TRIP))
      else $error("mode 0 did not trip at once");
   a_mode1_silent: assert property ( // see R2
      @(posedge clk) disable iff (!nrst)
      (failNow && mode1 && !undervoltageAlarm)
      |=> (!driveOn && !undervoltageAlarm && state == ST_FAIL))
      else $error("mode 1 raised alarm on failure");
   a_mode1_restore: assert property ( // see R3
      @(posedge clk) disable iff (!nrst)
      (restoreNow && mode1) |=> (undervoltageAlarm && !driveOn))
      else $error("mode 1 restore without alarm");
   a_mode2_decel: assert property ( // see R4
      @(posedge clk) disable iff (!nrst)
      lowBus |=> (decelStop && driveOn && state == ST_DECEL))
      else $error("decelerate-to-stop not started");
   a_mode2_alarm: assert property ( // see R5
      @(posedge clk) disable iff (!nrst)
      (state == ST_DECEL)
      |=> (undervoltageAlarm == $past(decelDone)))
      else $error("alarm raised before deceleration ended");
   a_mode4_latch: assert property ( // see R6
      @(posedge clk) disable iff (!nrst)
      (failNow && mode4) |=> (savedFreq == $past(outFreq) && !driveOn))
      else $error("mode 4 frequency not latched");
   a_mode4_resume: assert property ( // see R7
      @(posedge clk) disable iff (!nrst)
      (restartNow && mode4)
      |=> (restartStrobe && driveOn && restartFreq == savedFreq))
      else $error("mode 4 resumed at wrong frequency");
   a_mode5_start: assert property ( // see R8
      @(posedge clk) disable iff (!nrst)
      (restartNow && !mode4)
      |=> (restartStrobe && restartFreq == $past(startFreq)))
      else $error("restart not at starting frequency");
   a_run_window: assert property ( // see R16
      @(posedge clk) disable iff (!nrst)
      cancelNow |=> (state == ST_IDLE && !driveOn && !restartStrobe))
      else $error("restart not cancelled after wait");
   a_restart_delay: assert property ( // see R17
      @(posedge clk) disable iff (!nrst)
      (state == ST_WAIT_RUN && !delayExp) |=> !driveOn)
      else $error("restart before delay elapsed");
endmodule // mpfr_top
`default_nettype wire

// ==== verif/mpfr_stage_model.sv ====
`default_nettype none
module mpfr_stage_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // from the block
   input  wire logic        tuneStart,
   input  wire logic        driveOn,
   input  wire logic        decelStop,
   // tuning engine and ramp
   output logic             tuneDone,
   output logic      [15:0] tuneNoLoad,
   output logic      [15:0] tuneR1,
   output logic      [15:0] tuneX,
   output logic      [15:0] tuneSlip,
   output logic      [15:0] outFreq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] tuneCnt;
   // ==========================================================
   // results valid only with the done pulse
   assign tuneDone   = (tuneCnt == 3'h5);
   assign tuneNoLoad = tuneDone ? 16'h0123 : 16'hFEDC;
   assign tuneR1     = tuneDone ? 16'h0456 : 16'hFBA9;
   assign tuneX      = tuneDone ? 16'h0789 : 16'hF876;
   assign tuneSlip   = tuneDone ? 16'h0321 : 16'hFCDE;
   // ==========================================================
   // ramp falls by 100 a cycle while stopping
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tuneCnt <= 3'h0;
         outFreq <= 16'h0000;
      end else begin
         tuneCnt <= !tuneStart ? 3'h0 : tuneCnt + {2'h0, tuneCnt != 3'h6};
         outFreq <= decelStop ? (outFreq > 16'h0064 ? outFreq - 16'h0064
                    : 16'h0000) : (driveOn ? 16'h01F4 : 16'h0000);
      end
   end
endmodule // mpfr_stage_model
`default_nettype wire

// ==== verif/mpfr_top_tb_top.sv ====
`default_nettype none
module mpfr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'h0, nrst = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0;
   logic        uvDetect = 1'h0, readyToRun = 1'h1, runCmd = 1'h0;
   logic        alarmClear = 1'h0;
   logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000;
   logic [15:0] dcLinkVolts = 16'h012C;
   logic [15:0] regRdData, outFreq, tuneNoLoad, tuneR1, tuneX, tuneSlip;
   logic [15:0] restartFreq, driveSlipGain, brakeSlipGain;
   logic        regAck, regErr, tuneDone, tuneStart, driveOn, decelStop;
   logic        undervoltageAlarm, restartStrobe;
   logic [5:0]  ev;
   int          n_fail = 0, tests_run = 0;
   time         tFail;
   assign ev = {decelStop, tuneDone, undervoltageAlarm, restartStrobe,
                !driveOn, driveOn};
   always #20 clk = ~clk;
   mpfr_top #(.RUN_WAIT_CYC(40), .DELAY_STEP_CYC(4)) u_mpfr_top (.clk,
      .nrst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regAck,
      .regErr, .uvDetect, .readyToRun, .runCmd, .alarmClear, .dcLinkVolts,
      .outFreq, .tuneDone, .tuneNoLoad, .tuneR1, .tuneX, .tuneSlip,
      .tuneStart, .driveOn, .decelStop, .undervoltageAlarm, .restartStrobe,
      .restartFreq, .driveSlipGain, .brakeSlipGain);
   mpfr_stage_model u_mpfr_stage_model (.clk, .nrst, .tuneStart, .driveOn,
      .decelStop, .tuneDone, .tuneNoLoad, .tuneR1, .tuneX, .tuneSlip,
      .outFreq);
   // ==========================================================
   // shared helpers
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic waitev(int i);
      int k;
      k = 0;
      while (ev[i] !== 1'h1 && k < 400) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 400) begin
         chk("wait", 16'h0000, 16'h0001);
         stop_test();
      end
   endtask
   task automatic acc(logic w, logic [15:0] a, d, logic e, logic [15:0] r);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= w;
      regRdEn <= !w;
      @(posedge clk);
      regWrEn <= 1'h0;
      regRdEn <= 1'h0;
      #1;
      chk("ack", {15'h0, regAck}, 16'h0001);
      chk("err", {15'h0, regErr}, {15'h0, e});
      if (!w) chk("rdata", regRdData, r);
   endtask
   task automatic wr(logic [15:0] a, d, logic e);
      acc(1'h1, a, d, e, 16'h0000);
   endtask
   task automatic rd(logic [15:0] a, r);
      acc(1'h0, a, 16'h0000, 1'h0, r);
   endtask
   task automatic run_on(logic [15:0] f);
      @(posedge clk);
      runCmd <= 1'h1;
      waitev(2);
      chk("startf", restartFreq, f);
   endtask
   task automatic pfail(logic [15:0] m, f);
      wr(16'h000C, m, 1'h0);
      run_on(f);
      cyc(4);
      uvDetect <= 1'h1;
      readyToRun <= 1'h0;
      waitev(1);
      tFail = $time;
      @(posedge clk);
      uvDetect <= 1'h0;
   endtask
   task automatic restore();
      cyc(6);
      readyToRun <= 1'h1;
   endtask
   task automatic clear();
      @(posedge clk);
      runCmd <= 1'h0;
      alarmClear <= 1'h1;
      readyToRun <= 1'h1;
      cyc(5);
      alarmClear <= 1'h0;
      cyc(5);
      #1;
      chk("alarm", {15'h0, undervoltageAlarm}, 16'h0000);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_defaults();
      logic [15:0] a [8] = '{16'h0207, 16'h0208, 16'h0209, 16'h031B,
                             16'h000C, 16'h0012, 16'h0319, 16'h0203};
      logic [15:0] v [8] = '{16'h03E8, 16'h0064, 16'h03E8, 16'h00EB,
                             16'h0001, 16'h000A, 16'h0005, 16'h0000};
      for (int i = 0; i < 8; i++) begin
         rd(a[i], v[i]);
      end
   endtask
   task automatic t_ranges();
      wr(16'h0201, 16'h0BB9, 1'h1);
      rd(16'h0201, 16'h0028);
      wr(16'h0201, 16'h0BB8, 1'h0);
      wr(16'h0202, 16'h2711, 1'h1);
      wr(16'h0202, 16'h2710, 1'h0);
      wr(16'h0208, 16'h0000, 1'h1);
      wr(16'h0208, 16'h03E9, 1'h1);
      wr(16'h020A, 16'h05DD, 1'h1);
      wr(16'h020A, 16'h05DC, 1'h0);
      wr(16'h0207, 16'h07D0, 1'h0);
      wr(16'h0209, 16'h07D1, 1'h1);
      wr(16'h031B, 16'h012D, 1'h1);
      wr(16'h000C, 16'h0003, 1'h1);
      rd(16'h000C, 16'h0001);
      wr(16'h0203, 16'h0002, 1'h1);
      acc(1'h0, 16'h0300, 16'h0000, 1'h1, 16'h0000);
      chk("dgain", driveSlipGain, 16'h07D0);
      chk("bgain", brakeSlipGain, 16'h03E8);
   endtask
   task automatic t_tune();
      wr(16'h0203, 16'h0001, 1'h0);
      waitev(4);
      cyc(2);
      rd(16'h0204, 16'h0123);
      rd(16'h0205, 16'h0456);
      rd(16'h0206, 16'h0789);
      rd(16'h020A, 16'h0321);
      rd(16'h0203, 16'h0000);
   endtask
   task automatic t_modes();
      pfail(16'h0000, 16'h000A);
      chk("m0", {15'h0, undervoltageAlarm}, 16'h0001);
      clear();
      pfail(16'h0001, 16'h000A);
      chk("m1", {15'h0, undervoltageAlarm}, 16'h0000);
      restore();
      waitev(3);
      chk("m1on", {15'h0, driveOn}, 16'h0000);
      clear();
      pfail(16'h0004, 16'h000A);
      restore();
      waitev(2);
      chk("m4", restartFreq, 16'h01F4);
      chk("dly", {15'h0, ($time - tFail) >= 800}, 16'h0001);
      clear();
      wr(16'h0012, 16'h0014, 1'h0);
      pfail(16'h0005, 16'h0014);
      restore();
      waitev(2);
      chk("m5", restartFreq, 16'h0014);
      clear();
   endtask
   task automatic t_cancel_decel();
      pfail(16'h0004, 16'h0014);
      runCmd <= 1'h0;
      restore();
      cyc(70);
      run_on(16'h0014);
      clear();
      wr(16'h000C, 16'h0002, 1'h0);
      run_on(16'h0014);
      @(posedge clk);
      dcLinkVolts <= 16'h00E6;
      waitev(5);
      chk("m2", {15'h0, undervoltageAlarm}, 16'h0000);
      waitev(3);
      chk("m2f", outFreq, 16'h0000);
      @(posedge clk);
      dcLinkVolts <= 16'h012C;
      clear();
   endtask
   initial begin
      cyc(8);
      nrst <= 1'h1;
      t_defaults();
      t_ranges();
      t_tune();
      t_modes();
      t_cancel_decel();
      stop_test();
   end
endmodule // mpfr_top_tb_top
`default_nettype wire
